//--- inc/qbio_pkg.sv
package qbio_pkg;

   // ****************************************
   // port register addresses
   // ****************************************
   localparam logic [7:0] PORT_ZERO_ADDR = 8'h80;
   localparam logic [7:0] PORT_ONE_ADDR = 8'h90;
   localparam logic [7:0] PORT_TWO_ADDR = 8'hA0;
   localparam logic [7:0] PORT_THREE_ADDR = 8'hB0;
   localparam logic [7:0] PORT_FOUR_ADDR = 8'hD8;

   // ****************************************
   // widths, counts and reset values
   // ****************************************
   localparam int PORT_W = 8;
   localparam int PORT_FOUR_W = 4;
   localparam int NUM_PORTS = 5;
   localparam int LINE_COUNT = 36;
   localparam int IDX_W = 3;
   localparam logic [2:0] IDX_NONE = 3'h7;
   localparam logic [7:0] LATCH_RST = 8'hFF;
   localparam logic [7:0] PORT_FOUR_MASK = 8'h0F;
   localparam logic [7:0] BUS_READ_FORCE = 8'hFF;
   localparam logic [3:0] PULLUP_ON = 4'hF;

   // ****************************************
   // register address to port index
   // ****************************************
   function automatic logic [2:0] port_index(input logic [7:0] addr);
      logic [2:0] idx;
      idx = IDX_NONE;
      case (addr)
         PORT_ZERO_ADDR: idx = 3'h0;
         PORT_ONE_ADDR: idx = 3'h1;
         PORT_TWO_ADDR: idx = 3'h2;
         PORT_THREE_ADDR: idx = 3'h3;
         PORT_FOUR_ADDR: idx = 3'h4;
         default: idx = IDX_NONE;
      endcase
      return idx;
   endfunction

   // ****************************************
   // bits that exist in a port
   // ****************************************
   function automatic logic [7:0] port_mask(input logic [2:0] idx);
      return (idx == 3'h4) ? PORT_FOUR_MASK : LATCH_RST;
   endfunction

endpackage

//--- inc/qbio_sync_if.sv
interface qbio_sync_if #(parameter int W = 36);
   logic [W-1:0] raw;
   logic [W-1:0] sync;
   modport src (output raw, input sync);
   modport dst (input raw, output sync);
endinterface

//--- verilog/qbio_pin_sync.sv
module qbio_pin_sync #(
   parameter int W = 36
) (
   input wire logic mclk,
   input wire logic srst,
   qbio_sync_if.dst pins
);

   // ****************************************
   // two flip-flop synchroniser
   // ****************************************
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;

   always_comb begin
      meta_d = pins.raw;
      sync_d = meta_q;
      if (srst) begin
         meta_d = '1;
         sync_d = '1;
      end
   end

   always_ff @(posedge mclk) begin
      meta_q <= meta_d;
      sync_q <= sync_d;
   end

   assign pins.sync = sync_q;

endmodule

//--- verilog/qbio_ports.sv
// Summary of operation
// - thirty-six lines: four byte ports, one nibble
// - each line follows only its own latch, except port zero lines in bus mode
// - latch zero turns pull-down on
// - latch one releases; weak pull-up holds high, except on port zero
// - reset sets every existing latch bit to one (port four latch reads 0Fh)
// - weak pull-up stays on for inputs
// - port zero open drain, no pull-up outside bus mode
// - port zero pull-up only in bus mode
// - bus input transfer forces port zero latch
// - port zero latch at bit-addressable 80h
// - bit n drives port zero line n
module qbio_ports (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_rd,
   input wire logic sfr_rd_latch,
   input wire logic sfr_bit_wr,
   input wire logic [7:0] sfr_bit_addr,
   input wire logic sfr_bit_wdata,
   output logic [7:0] sfr_rdata,
   output logic sfr_rd_hit,
   input wire logic ext_bus_en,
   input wire logic ext_bus_drive,
   input wire logic [7:0] ext_bus_wdata,
   input wire logic ext_bus_read,
   output logic [7:0] ext_bus_rdata,
   output logic port_zero_pullup_en,
   output logic [3:0] weak_pullup_en,
   input wire logic [7:0] port_zero_in,
   output logic [7:0] port_zero_out,
   output logic [7:0] port_zero_oe_n,
   input wire logic [7:0] port_one_in,
   output logic [7:0] port_one_out,
   output logic [7:0] port_one_oe_n,
   input wire logic [7:0] port_two_in,
   output logic [7:0] port_two_out,
   output logic [7:0] port_two_oe_n,
   input wire logic [7:0] port_three_in,
   output logic [7:0] port_three_out,
   output logic [7:0] port_three_oe_n,
   input wire logic [3:0] port_four_in,
   output logic [3:0] port_four_out,
   output logic [3:0] port_four_oe_n
);

   // ****************************************
   // pin synchronisers
   // ****************************************
   qbio_sync_if #(.W(qbio_pkg::LINE_COUNT)) pin_if ();

   assign pin_if.raw = {port_four_in, port_three_in, port_two_in, port_one_in, port_zero_in};

   qbio_pin_sync #(.W(qbio_pkg::LINE_COUNT)) u_sync (
      .mclk(mclk),
      .srst(srst),
      .pins(pin_if)
   );

   logic [7:0] pin_sync [qbio_pkg::NUM_PORTS];

   always_comb begin
      pin_sync[0] = pin_if.sync[7:0];
      pin_sync[1] = pin_if.sync[15:8];
      pin_sync[2] = pin_if.sync[23:16];
      pin_sync[3] = pin_if.sync[31:24];
      pin_sync[4] = {4'h0, pin_if.sync[35:32]};
   end

   // ****************************************
   // port latches
   // ****************************************
   logic [7:0] latch_q [qbio_pkg::NUM_PORTS];
   logic [7:0] latch_d [qbio_pkg::NUM_PORTS];
   logic [2:0] wr_idx;
   logic [2:0] bit_idx;

   assign wr_idx = qbio_pkg::port_index(sfr_addr);
   assign bit_idx = qbio_pkg::port_index({sfr_bit_addr[7:3], 3'h0});

   always_comb begin
      for (int i = 0; i < qbio_pkg::NUM_PORTS; i++) begin
         latch_d[i] = latch_q[i];
         if (sfr_wr && wr_idx == i[2:0]) begin
            latch_d[i] = sfr_wdata & qbio_pkg::port_mask(i[2:0]);
         end
         if (sfr_bit_wr && bit_idx == i[2:0]) begin
            latch_d[i][sfr_bit_addr[2:0]] = sfr_bit_wdata & |(qbio_pkg::port_mask(i[2:0]) & (8'h01 << sfr_bit_addr[2:0]));
         end
         if (srst) begin
            latch_d[i] = qbio_pkg::port_mask(i[2:0]);
         end
      end
      if (ext_bus_read && !srst) begin
         latch_d[0] = qbio_pkg::BUS_READ_FORCE;
      end
   end

   always_ff @(posedge mclk) begin
      latch_q <= latch_d;
   end

   // ****************************************
   // output stage
   // ****************************************
   logic [7:0] p0_out_q, p0_out_d, p0_oe_n_q, p0_oe_n_d;
   logic [7:0] p1_oe_n_q, p2_oe_n_q, p3_oe_n_q, p4_oe_n_q;
   logic [7:0] p1_oe_n_d, p2_oe_n_d, p3_oe_n_d, p4_oe_n_d;
   logic p0_pu_q, p0_pu_d;
   logic [3:0] wpu_q, wpu_d;

   always_comb begin
      p0_out_d = 8'h00;
      p0_oe_n_d = latch_q[0];
      p0_pu_d = 1'b0;
      if (ext_bus_en) begin
         p0_pu_d = 1'b1;
         p0_out_d = ext_bus_wdata;
         p0_oe_n_d = ext_bus_drive ? 8'h00 : 8'hFF;
      end
      p1_oe_n_d = latch_q[1];
      p2_oe_n_d = latch_q[2];
      p3_oe_n_d = latch_q[3];
      p4_oe_n_d = latch_q[4] | ~qbio_pkg::PORT_FOUR_MASK;
      wpu_d = qbio_pkg::PULLUP_ON;
      if (srst) begin
         p0_out_d = 8'h00;
         p0_oe_n_d = qbio_pkg::LATCH_RST;
         p0_pu_d = 1'b0;
         p1_oe_n_d = qbio_pkg::LATCH_RST;
         p2_oe_n_d = qbio_pkg::LATCH_RST;
         p3_oe_n_d = qbio_pkg::LATCH_RST;
         p4_oe_n_d = qbio_pkg::LATCH_RST;
      end
   end

   always_ff @(posedge mclk) begin
      p0_out_q <= p0_out_d;
      p0_oe_n_q <= p0_oe_n_d;
      p0_pu_q <= p0_pu_d;
      p1_oe_n_q <= p1_oe_n_d;
      p2_oe_n_q <= p2_oe_n_d;
      p3_oe_n_q <= p3_oe_n_d;
      p4_oe_n_q <= p4_oe_n_d;
      wpu_q <= wpu_d;
   end

   assign port_zero_out = p0_out_q;
   assign port_zero_oe_n = p0_oe_n_q;
   assign port_zero_pullup_en = p0_pu_q;
   assign weak_pullup_en = wpu_q;
   assign port_one_out = 8'h00;
   assign port_one_oe_n = p1_oe_n_q;
   assign port_two_out = 8'h00;
   assign port_two_oe_n = p2_oe_n_q;
   assign port_three_out = 8'h00;
   assign port_three_oe_n = p3_oe_n_q;
   assign port_four_out = 4'h0;
   assign port_four_oe_n = p4_oe_n_q[3:0];

   // ****************************************
   // register read path
   // ****************************************
   logic [7:0] rdata_q, rdata_d, bus_rdata_q, bus_rdata_d;
   logic rd_hit_q, rd_hit_d;

   always_comb begin
      rdata_d = 8'h00;
      rd_hit_d = 1'b0;
      bus_rdata_d = pin_sync[0];
      if (sfr_rd && wr_idx != qbio_pkg::IDX_NONE) begin
         rd_hit_d = 1'b1;
         rdata_d = sfr_rd_latch ? latch_q[wr_idx] : pin_sync[wr_idx];
      end
      if (srst) begin
         rdata_d = 8'h00;
         rd_hit_d = 1'b0;
         bus_rdata_d = 8'h00;
      end
   end

   always_ff @(posedge mclk) begin
      rdata_q <= rdata_d;
      rd_hit_q <= rd_hit_d;
      bus_rdata_q <= bus_rdata_d;
   end

   assign sfr_rdata = rdata_q;
   assign sfr_rd_hit = rd_hit_q;
   assign ext_bus_rdata = bus_rdata_q;

   // ****************************************
   // assertions
   // ****************************************
   sequence s_p1_write;
      sfr_wr && sfr_addr == qbio_pkg::PORT_ONE_ADDR && !sfr_bit_wr;
   endsequence

   sequence s_p1_drive(logic [7:0] v);
      ##1 latch_q[1] == v ##1 port_one_oe_n == v;
   endsequence

   property p_reset_inputs;
      @(posedge mclk) disable iff (srst) $fell(srst) |-> latch_q[0] == 8'hFF && latch_q[4] == 8'h0F;
   endproperty
   a_reset_inputs: assert property (p_reset_inputs) else $error("latches not released by reset");

   property p_write_drives;
      logic [7:0] v;
      @(posedge mclk) disable iff (srst) (s_p1_write, v = sfr_wdata) ##0 !ext_bus_read |-> s_p1_drive(v);
   endproperty
   a_write_drives: assert property (p_write_drives) else $error("port one write did not drive pins");

   property p_weak_pullup;
      @(posedge mclk) disable iff (srst) !$past(srst) |-> weak_pullup_en == 4'hF;
   endproperty
   a_weak_pullup: assert property (p_weak_pullup) else $error("weak pull-up dropped");

   property p_open_drain;
      @(posedge mclk) disable iff (srst) !ext_bus_en |=> port_zero_out == 8'h00 && port_zero_oe_n == $past(latch_q[0]);
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("port zero not open drain");

   property p_bus_pullup;
      @(posedge mclk) disable iff (srst) ##1 port_zero_pullup_en == $past(ext_bus_en);
   endproperty
   a_bus_pullup: assert property (p_bus_pullup) else $error("port zero pull-up outside bus mode");

   property p_bus_read_force;
      @(posedge mclk) disable iff (srst) ext_bus_read |=> latch_q[0] == 8'hFF;
   endproperty
   a_bus_read_force: assert property (p_bus_read_force) else $error("bus read did not force latch");

   property p_bit_write;
      @(posedge mclk) disable iff (srst)
         sfr_bit_wr && sfr_bit_addr[7:3] == 5'h10 && !sfr_wr && !ext_bus_read
         |=> latch_q[0][$past(sfr_bit_addr[2:0])] == $past(sfr_bit_wdata);
   endproperty
   a_bit_write: assert property (p_bit_write) else $error("port zero bit write lost");

   property p_bit_isolated;
      @(posedge mclk) disable iff (srst)
         sfr_bit_wr && sfr_bit_addr[7:3] == 5'h12 && !sfr_wr
         |=> ((latch_q[1] ^ $past(latch_q[1])) & ~(8'h01 << $past(sfr_bit_addr[2:0]))) == 8'h00;
   endproperty
   a_bit_isolated: assert property (p_bit_isolated) else $error("bit write disturbed neighbour");

   property p_pin_read;
      @(posedge mclk) disable iff (srst)
         sfr_rd && !sfr_rd_latch && sfr_addr == qbio_pkg::PORT_ZERO_ADDR |=> sfr_rd_hit && sfr_rdata == $past(pin_sync[0]);
   endproperty
   a_pin_read: assert property (p_pin_read) else $error("port read not pin level");

endmodule

//--- testbench/qbio_pin_model.sv
// ****************************************
// external circuitry on the 36 port pins
// ****************************************
module qbio_pin_model (
   input wire logic [35:0] oe_n,
   input wire logic [35:0] outv,
   input wire logic [35:0] drv_en,
   input wire logic [35:0] drv_val,
   output logic [35:0] pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // driven port outputs win, then external drivers; released lines are pulled high (resistor on port zero, weak pull-up elsewhere)
   always_comb begin
      for (int i = 0; i < 36; i++) begin
         pin[i] = !oe_n[i] ? outv[i] : (drv_en[i] ? drv_val[i] : 1'b1);
      end
   end
endmodule

//--- testbench/quasi_bidir_io_ports_bench.sv
module quasi_bidir_io_ports_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // stimulus and observed signals
   // ****************************************
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] sfr_addr = 8'h00;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_bit_addr = 8'h00;
   logic [7:0] ext_bus_wdata = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic sfr_rd_latch = 1'b0;
   logic sfr_bit_wr = 1'b0;
   logic sfr_bit_wdata = 1'b0;
   logic ext_bus_en = 1'b0;
   logic ext_bus_drive = 1'b0;
   logic ext_bus_read = 1'b0;
   logic [35:0] drv_en = 36'h0;
   logic [35:0] drv_val = 36'h0;
   int failures = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [35:0] pin;
   wire [35:0] oe_n;
   wire [35:0] outv;
   logic [7:0] rdata;
   logic [7:0] bus_rdata;
   logic [3:0] wpu;
   logic rd_hit;
   logic pz_pu;
   always #4 mclk = ~mclk;
   qbio_ports uut (.mclk(mclk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
      .sfr_rd(sfr_rd), .sfr_rd_latch(sfr_rd_latch), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_addr(sfr_bit_addr),
      .sfr_bit_wdata(sfr_bit_wdata), .sfr_rdata(rdata), .sfr_rd_hit(rd_hit), .ext_bus_en(ext_bus_en),
      .ext_bus_drive(ext_bus_drive), .ext_bus_wdata(ext_bus_wdata), .ext_bus_read(ext_bus_read),
      .ext_bus_rdata(bus_rdata), .port_zero_pullup_en(pz_pu), .weak_pullup_en(wpu),
      .port_zero_in(pin[7:0]), .port_zero_out(outv[7:0]), .port_zero_oe_n(oe_n[7:0]),
      .port_one_in(pin[15:8]), .port_one_out(outv[15:8]), .port_one_oe_n(oe_n[15:8]),
      .port_two_in(pin[23:16]), .port_two_out(outv[23:16]), .port_two_oe_n(oe_n[23:16]),
      .port_three_in(pin[31:24]), .port_three_out(outv[31:24]), .port_three_oe_n(oe_n[31:24]),
      .port_four_in(pin[35:32]), .port_four_out(outv[35:32]), .port_four_oe_n(oe_n[35:32]));
   qbio_pin_model pins (.oe_n(oe_n), .outv(outv), .drv_en(drv_en), .drv_val(drv_val), .pin(pin));
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic end_sim;
      if (failures == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge mclk);
      sfr_wr <= 1'b0;
   endtask
   task automatic bwr(input logic [7:0] a, input logic d);
      @(posedge mclk);
      sfr_bit_addr <= a;
      sfr_bit_wdata <= d;
      sfr_bit_wr <= 1'b1;
      @(posedge mclk);
      sfr_bit_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic lat, input logic [7:0] exp, input logic hit);
      repeat (4) @(posedge mclk);
      sfr_addr <= a;
      sfr_rd_latch <= lat;
      sfr_rd <= 1'b1;
      @(posedge mclk);
      sfr_rd <= 1'b0;
      #1;
      chk(rdata, exp);
      chk(rd_hit, hit);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      #1;
      chk(oe_n, 36'hF_FFFF_FFFF);
      chk(wpu, qbio_pkg::PULLUP_ON);
      chk(pz_pu, 1'b0);
      rd(qbio_pkg::PORT_ZERO_ADDR, 1'b1, 8'hFF, 1'b1);
      rd(qbio_pkg::PORT_ONE_ADDR, 1'b1, 8'hFF, 1'b1);
      rd(qbio_pkg::PORT_TWO_ADDR, 1'b1, 8'hFF, 1'b1);
      rd(qbio_pkg::PORT_THREE_ADDR, 1'b1, 8'hFF, 1'b1);
      rd(qbio_pkg::PORT_FOUR_ADDR, 1'b1, 8'h0F, 1'b1);
   endtask
   task automatic t_write;
      wr(qbio_pkg::PORT_ZERO_ADDR, 8'h55);
      wr(qbio_pkg::PORT_ONE_ADDR, 8'h55);
      wr(qbio_pkg::PORT_TWO_ADDR, 8'h55);
      wr(qbio_pkg::PORT_THREE_ADDR, 8'h55);
      wr(qbio_pkg::PORT_FOUR_ADDR, 8'h55);
      @(posedge mclk);
      #1;
      chk(oe_n, 36'h5_5555_5555);
      chk(outv, 36'h0);
      chk(pin, 36'h5_5555_5555);
      rd(qbio_pkg::PORT_ZERO_ADDR, 1'b0, 8'h55, 1'b1);
      rd(qbio_pkg::PORT_THREE_ADDR, 1'b0, 8'h55, 1'b1);
      rd(qbio_pkg::PORT_FOUR_ADDR, 1'b0, 8'h05, 1'b1);
   endtask
   task automatic t_input;
      wr(qbio_pkg::PORT_ONE_ADDR, 8'hFF);
      drv_en[11] <= 1'b1;
      drv_val[11] <= 1'b0;
      rd(qbio_pkg::PORT_ONE_ADDR, 1'b0, 8'hF7, 1'b1);
      rd(qbio_pkg::PORT_ONE_ADDR, 1'b1, 8'hFF, 1'b1);
      @(posedge mclk);
      drv_en[11] <= 1'b0;
   endtask
   task automatic t_bit;
      bwr(8'h80, 1'b0);
      bwr(8'h83, 1'b1);
      rd(qbio_pkg::PORT_ZERO_ADDR, 1'b1, 8'h5C, 1'b1);
      chk(oe_n[7:0], 8'h5C);
      bwr(8'h92, 1'b0);
      rd(qbio_pkg::PORT_ONE_ADDR, 1'b1, 8'hFB, 1'b1);
      chk(oe_n[15:8], 8'hFB);
   endtask
   task automatic t_bus;
      @(posedge mclk);
      ext_bus_en <= 1'b1;
      ext_bus_drive <= 1'b1;
      ext_bus_wdata <= 8'hA5;
      repeat (2) @(posedge mclk);
      #1;
      chk({pz_pu, oe_n[7:0], outv[7:0]}, {1'b1, 8'h00, 8'hA5});
      @(posedge mclk);
      ext_bus_drive <= 1'b0;
      ext_bus_read <= 1'b1;
      drv_en[7:0] <= 8'hFF;
      drv_val[7:0] <= 8'h3C;
      repeat (5) @(posedge mclk);
      #1;
      chk(bus_rdata, 8'h3C);
      @(posedge mclk);
      ext_bus_read <= 1'b0;
      ext_bus_en <= 1'b0;
      drv_en[7:0] <= 8'h00;
      repeat (2) @(posedge mclk);
      #1;
      chk(pz_pu, 1'b0);
      rd(qbio_pkg::PORT_ZERO_ADDR, 1'b1, 8'hFF, 1'b1);
   endtask
   task automatic t_unmapped;
      wr(8'h81, 8'h00);
      rd(8'h81, 1'b1, 8'h00, 1'b0);
      chk(oe_n[7:0], 8'hFF);
   endtask
   task automatic t_rereset;
      @(posedge mclk);
      srst <= 1'b1;
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      #1;
      chk(oe_n, 36'hF_FFFF_FFFF);
      chk(wpu, qbio_pkg::PULLUP_ON);
      rd(qbio_pkg::PORT_TWO_ADDR, 1'b1, 8'hFF, 1'b1);
      rd(qbio_pkg::PORT_FOUR_ADDR, 1'b1, 8'h0F, 1'b1);
   endtask
   // ****************************************
   // main sequence and watchdog
   // ****************************************
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         end_sim();
      end
   end
   initial begin
      repeat (16) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      t_reset();
      t_write();
      t_input();
      t_bit();
      t_bus();
      t_unmapped();
      t_rereset();
      end_sim();
   end
endmodule
